// ### logic/ssfm_master.sv
// Clock synchronous serial channel driving a serial flash, with an APB
// register slave and a general port bit for the flash select line.
// Assumes one clock pclk, async active-low reset, and software pacing.
// Notes on behaviour
// RQ1: Flash select comes from a plain port register bit, not from the shifter.
// RQ2: Software waits after select falls before writing data to start clocking.
// RQ3: Software waits after the last rising clock before raising select.
// RQ4: Start: select high, clock idles high, enable serial mode, then select low.
// RQ5: End: select high, serial off, pins return to port use driven high.
// RQ6: Transmit interrupt level field kept zero; software polls the request flag.
// RQ7: With cause select zero, transmit request raised when buffer becomes empty.
// RQ8: Mode field value one selects clock synchronous operation.
// RQ9: Internal clock; rate from eight-bit divider and two-bit prescale select.
// RQ10: Data changes on falling clock edge, sampled on rising edge.
// RQ11: Bit order select one shifts most significant bit first.
// RQ12: Flow control disabled; flow pin select has no effect.
// RQ13: Output type select zero gives push-pull drive, no open drain.
// RQ14: Transmit and receive enables reset to zero; writing one enables each.
// RQ15: Read-only flags: buffer empty, receive complete, shift register empty.
// RQ16: Eight-bit receive buffer with overrun error flag.
// RQ17: Continuous receive mode bit stays zero.
// RQ18: Data invert, logic invert and clock stop bits held zero.
// RQ19: Request flag reads one when requested; software writes zero to clear.
// RQ20: DMA request output is the transmit interrupt request.
// RQ21: Pick a channel with push-pull outputs, not open-drain only.
// RQ22: Four special-mode registers reset to zero.
// RQ23: Each buffer write launches eight clocks, full duplex, receive flag at end.
`timescale 1ns/100ps
`include "ssfm_consts.svh"

// Register map, one byte per APB word in bits 7:0, upper bits read zero except the overrun bit at 0x04
//   0x00 transmit buffer, write only; a write arms one transfer
//   0x04 receive buffer; bits 7:0 data, bit 12 overrun
//        a read clears the receive complete flag and the overrun flag
//   0x08 baud divider, eight bits, reload value of the half-period counter
//   0x0c mode: bits 2:0 serial mode, bit 3 clock source, bit 6 data invert
//   0x10 control 0: bits 1:0 prescale select, bit 2 flow pin select,
//        bit 3 shift register empty (read only), bit 4 flow control off,
//        bit 5 output type, bit 6 clock edge select, bit 7 msb first
//   0x14 control 1: bit 0 transmit enable, bit 1 buffer empty (read only),
//        bit 2 receive enable, bit 3 receive complete (read only),
//        bit 4 request cause select, bit 5 continuous receive,
//        bit 6 logic invert, bit 7 clock stop
//   0x18 to 0x24 four special-mode registers, plain storage
//   0x28 transmit request control: bits 2:0 level, bit 3 request flag
//   0x2c port: bit 0 select level, bit 1 hands the pins to the shifter
//   Anything else reads zero and ignores writes; no slave error
//
// Limitations worth knowing
//   Edge select, invert, clock stop and continuous receive are stored only;
//   the shifter always runs idle-high, fall-drive, rise-sample, plain data.
//   Output type select is stored only; every pin is push-pull.
//   The level field never gates anything: there is no interrupt output,
//   software polls the request flag or lets the DMA unit watch it.
//   The select guard times are software's job; the shift register empty
//   flag tells software when the last rising clock has gone by.
//
// Transfer timing with divider value n and prescale factor p
//   A half period lasts (n + 1) * p clock cycles.
//   The first clock edge toward the flash is a falling one; data moves
//   on each fall and the returning bit is taken on each rise.
//   Eight falls and eight rises make one byte; the receive byte lands
//   together with the eighth rise.
//   A second buffer write during a transfer waits in the buffer and
//   starts as soon as the engine is idle again.

module ssfm_master
  import ssfm_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             flash_cs_n,
  output logic             flash_sclk,
  output logic             flash_mosi,
  input  wire logic        flash_miso,
  output logic             dma_req
);

  ssfm_apb_req_s req;
  logic          wr_acc;
  logic          rd_acc;
  logic [7:0]    brg_q;
  logic [7:0]    mode_q;
  logic [7:0]    c0_q;
  logic [7:0]    c1_q;
  logic [7:0]    smr_q [4];
  logic [7:0]    txic_q;
  logic [1:0]    port_q;
  logic [7:0]    txb_q;
  logic          txb_full_q;
  logic [7:0]    sh_q;
  logic [7:0]    rxb_q;
  logic          oer_q;
  logic          ri_q;
  ssfm_state_e   st_q;
  logic [2:0]    bit_q;
  logic          sclk_q;
  logic          mosi_q;
  logic [7:0]    pre_q;
  logic [7:0]    brg_cnt_q;
  logic          tick;
  logic          load;
  logic          done;
  logic          serial_on;
  logic          msb_first;

  // Register index decode, used by read and write paths
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // Prescale divide factor: 1, 8, 32 or unused as 1
  function automatic logic [7:0] pre_div(input logic [1:0] s);
    case (s)
      2'h1:    pre_div = 8'h07;
      2'h2:    pre_div = 8'h1f;
      default: pre_div = 8'h00;
    endcase
  endfunction

  assign req       = '{psel, penable, pwrite, paddr, pwdata};
  assign wr_acc    = req.sel & req.enable & req.write;
  assign rd_acc    = req.sel & req.enable & ~req.write;
  assign pready    = 1'b1;                             // Zero wait states
  assign pslverr   = 1'b0;
  assign serial_on = port_q[`SSFM_PORT_FUNC]
                   & (mode_q[`SSFM_MODE_SMD_LO +: 3] == `SSFM_SMD_CSYNC); // RQ8
  assign msb_first = c0_q[`SSFM_C0_MSB];                                  // RQ11
  assign load      = (st_q == SSFM_IDLE) & txb_full_q & serial_on
                   & c1_q[`SSFM_C1_TE];                                   // RQ23
  // Last rising clock of the byte: the engine sees sclk low before the rise
  assign done      = (st_q == SSFM_SHIFT) & tick & ~sclk_q & (bit_q == 3'h7); // RQ3

  // Baud divider; the rate follows from this value and the prescale select
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      brg_q <= `SSFM_RST_ZERO;
    end else if (wr_acc && hit(req.addr, `SSFM_OFF_BRG)) begin
      brg_q <= req.wdata[7:0];                         // RQ9
    end
  end

  // Mode register; only a serial mode field (bits 2:0) of one lets the shifter run
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_q <= `SSFM_RST_ZERO;
    end else if (wr_acc && hit(req.addr, `SSFM_OFF_MODE)) begin
      mode_q <= req.wdata[7:0];                        // RQ8
    end
  end

  // Control 0; the read-only empty bit is never stored
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c0_q <= `SSFM_RST_ZERO;
    end else if (wr_acc && hit(req.addr, `SSFM_OFF_CTRL0)) begin
      c0_q <= {req.wdata[7:4], 1'b0, req.wdata[2:0]}; // RQ12 RQ13
    end
  end

  // Request control; the flag bit lives in the request flop instead
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txic_q <= `SSFM_RST_ZERO;
    end else if (wr_acc && hit(req.addr, `SSFM_OFF_TXIC)) begin
      txic_q <= {req.wdata[7:4], 1'b0, req.wdata[2:0]}; // RQ6
    end
  end

  // Port bits; select idles high so the flash stays quiet after reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      port_q <= `SSFM_RST_PORT;                        // RQ5
    end else if (wr_acc && hit(req.addr, `SSFM_OFF_PORT)) begin
      port_q <= req.wdata[1:0];                        // RQ1
    end
  end

  // Special-mode registers, zero from reset
  generate
    for (genvar i = 0; i < 4; i++) begin : g_smr
      always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
          smr_q[i] <= `SSFM_RST_ZERO;                  // RQ22
        end else if (wr_acc && hit(req.addr, 12'(`SSFM_OFF_SMR1 + 4 * i))) begin
          smr_q[i] <= req.wdata[7:0];
        end
      end
    end
  endgenerate

  // Control 1: enables and option bits; flags live elsewhere
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      c1_q <= `SSFM_RST_ZERO;                          // RQ14
    end else if (wr_acc && hit(req.addr, `SSFM_OFF_CTRL1)) begin
      c1_q <= {req.wdata[7:4], 1'b0, req.wdata[2], 1'b0, req.wdata[0]}; // RQ14 RQ17 RQ18
    end
  end

  // Transmit buffer; a write while busy overwrites the pending byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      txb_q      <= `SSFM_RST_ZERO;
      txb_full_q <= 1'b0;
    end else if (wr_acc && hit(req.addr, `SSFM_OFF_TXB)) begin
      txb_q      <= req.wdata[7:0];
      txb_full_q <= 1'b1;
    end else if (load) begin
      txb_full_q <= 1'b0;
    end
  end

  // Request flag: set on buffer drain with cause select zero, or on transfer end with cause select one; set wins over software clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dma_req <= 1'b0;
    end else if (load && !c1_q[`SSFM_C1_IRS]) begin
      dma_req <= 1'b1;                                 // RQ7 RQ20
    end else if (done && c1_q[`SSFM_C1_IRS]) begin
      dma_req <= 1'b1;
    end else if (wr_acc && hit(req.addr, `SSFM_OFF_TXIC) && !req.wdata[`SSFM_IC_IR]) begin
      dma_req <= 1'b0;                                 // RQ19
    end
  end

  // Baud generator: prescaler then eight-bit divider, one tick per half period
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pre_q     <= 8'h00;
      brg_cnt_q <= 8'h00;
    end else if (st_q == SSFM_IDLE) begin
      pre_q     <= 8'h00;
      brg_cnt_q <= 8'h00;
    end else if (pre_q != 8'h00) begin
      pre_q <= pre_q - 8'h01;
    end else begin
      pre_q     <= pre_div(c0_q[`SSFM_C0_CKS_LO +: 2]); // RQ9
      brg_cnt_q <= (brg_cnt_q == 8'h00) ? brg_q : brg_cnt_q - 8'h01;
    end
  end
  assign tick = (st_q != SSFM_IDLE) & (pre_q == 8'h00) & (brg_cnt_q == 8'h00);

  // Shift engine: fall edge drives, rise edge samples
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st_q   <= SSFM_IDLE;
      sh_q   <= 8'h00;
      bit_q  <= 3'h0;
      sclk_q <= 1'b1;
      mosi_q <= 1'b1;
    end else begin
      case (st_q)
        SSFM_IDLE: begin
          sclk_q <= 1'b1;                              // RQ4
          if (load) begin
            st_q  <= SSFM_SHIFT;                       // RQ2
            sh_q  <= txb_q;
            bit_q <= 3'h0;
          end
        end
        SSFM_SHIFT: begin
          if (tick) begin
            sclk_q <= ~sclk_q;
            if (sclk_q) begin
              mosi_q <= msb_first ? sh_q[7] : sh_q[0]; // RQ10 RQ11
            end else begin
              sh_q <= msb_first ? {sh_q[6:0], flash_miso}
                                : {flash_miso, sh_q[7:1]}; // RQ10
              bit_q <= bit_q + 3'h1;
              if (bit_q == 3'h7)
                st_q <= SSFM_IDLE;                     // RQ23
            end
          end
        end
        default: st_q <= SSFM_IDLE;
      endcase
    end
  end

  // Receive buffer, complete flag and overrun
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rxb_q <= 8'h00;
      ri_q  <= 1'b0;
      oer_q <= 1'b0;
    end else begin
      if (st_q == SSFM_SHIFT && tick && !sclk_q && bit_q == 3'h7 && c1_q[`SSFM_C1_RE]) begin
        rxb_q <= msb_first ? {sh_q[6:0], flash_miso} : {flash_miso, sh_q[7:1]};
        ri_q  <= 1'b1;                                 // RQ23
        if (ri_q)
          oer_q <= 1'b1;                               // RQ16
      end else if (rd_acc && hit(req.addr, `SSFM_OFF_RXB)) begin
        ri_q  <= 1'b0;
        oer_q <= 1'b0;
      end
    end
  end

  // Pins: push-pull always; port use drives clock and data high, select follows port bit 0
  always_comb begin
    flash_cs_n = port_q[`SSFM_PORT_CS];                // RQ1 RQ13 RQ21
    flash_sclk = serial_on ? sclk_q : 1'b1;            // RQ5
    flash_mosi = serial_on ? mosi_q : 1'b1;            // RQ5
  end

  // Read mux; status flags are read-only views of engine state
  always_comb begin
    prdata = 32'h0000_0000;
    if (rd_acc) begin
      if (hit(req.addr, `SSFM_OFF_RXB)) begin
        prdata[7:0]            = rxb_q;
        prdata[`SSFM_RXB_OER]  = oer_q;                // RQ16
      end
      if (hit(req.addr, `SSFM_OFF_BRG))   prdata[7:0] = brg_q;
      if (hit(req.addr, `SSFM_OFF_MODE))  prdata[7:0] = mode_q;
      if (hit(req.addr, `SSFM_OFF_CTRL0)) begin
        prdata[7:0]           = c0_q;
        prdata[`SSFM_C0_SHIFT_REG_EMPTY_FLAG] = (st_q == SSFM_IDLE) & ~txb_full_q; // RQ3 RQ15
      end
      if (hit(req.addr, `SSFM_OFF_CTRL1)) begin
        prdata[7:0]         = c1_q;
        prdata[`SSFM_C1_TI] = ~txb_full_q;             // RQ15
        prdata[`SSFM_C1_RI] = ri_q;                    // RQ15
      end
      for (int i = 0; i < 4; i++)
        if (hit(req.addr, 12'(`SSFM_OFF_SMR1 + 4 * i))) prdata[7:0] = smr_q[i];
      if (hit(req.addr, `SSFM_OFF_TXIC)) begin
        prdata[7:0]         = txic_q;
        prdata[`SSFM_IC_IR] = dma_req;                 // RQ6 RQ19
      end
      if (hit(req.addr, `SSFM_OFF_PORT))  prdata[1:0] = port_q;
    end
  end

endmodule

// ### logic/ssfm_consts.svh
// Register offsets, field positions and reset values
// for the synchronous serial flash master; included by the package user.
`ifndef SSFM_CONSTS_SVH
`define SSFM_CONSTS_SVH

// Byte offsets on the APB word map
`define SSFM_OFF_TXB      12'h000
`define SSFM_OFF_RXB      12'h004
`define SSFM_OFF_BRG      12'h008
`define SSFM_OFF_MODE     12'h00c
`define SSFM_OFF_CTRL0    12'h010
`define SSFM_OFF_CTRL1    12'h014
`define SSFM_OFF_SMR1     12'h018
`define SSFM_OFF_SMR2     12'h01c
`define SSFM_OFF_SMR3     12'h020
`define SSFM_OFF_SMR4     12'h024
`define SSFM_OFF_TXIC     12'h028
`define SSFM_OFF_PORT     12'h02c

// Mode register fields
`define SSFM_MODE_SMD_LO  0
`define SSFM_MODE_CLK_SOURCE_SEL   3
`define SSFM_MODE_DATA_INVERT_SEL   6
`define SSFM_SMD_CSYNC    3'h1

// Control 0 fields
`define SSFM_C0_CKS_LO    0
`define SSFM_C0_CRS       2
`define SSFM_C0_SHIFT_REG_EMPTY_FLAG     3
`define SSFM_C0_CRD       4
`define SSFM_C0_NCH       5
`define SSFM_C0_CLK_EDGE_SEL     6
`define SSFM_C0_MSB       7

// Control 1 fields
`define SSFM_C1_TE        0
`define SSFM_C1_TI        1
`define SSFM_C1_RE        2
`define SSFM_C1_RI        3
`define SSFM_C1_IRS       4
`define SSFM_C1_RRM       5
`define SSFM_C1_LCH       6
`define SSFM_C1_STP       7

// Receive buffer overrun flag position
`define SSFM_RXB_OER      12

// Interrupt control fields
`define SSFM_IC_IR        3

// Port register: bit0 select level, bit1 serial function enable
`define SSFM_PORT_CS      0
`define SSFM_PORT_FUNC    1

// Reset values
`define SSFM_RST_ZERO     8'h00
`define SSFM_RST_CTRL1    8'h02
`define SSFM_RST_PORT     2'h1

`endif

// ### logic/ssfm_pkg.sv
// Types shared by the synchronous serial flash master.
// Assumes the constants header is included by the design file.
package ssfm_pkg;

  typedef enum logic [1:0] {
    SSFM_IDLE,
    SSFM_SHIFT
  } ssfm_state_e;

  // APB request as seen by the slave
  typedef struct packed {
    logic        sel;
    logic        enable;
    logic        write;
    logic [11:0] addr;
    logic [31:0] wdata;
  } ssfm_apb_req_s;

  // Serial pin group toward the flash
  typedef struct packed {
    logic sclk;
    logic mosi;
    logic cs_n;
  } ssfm_pins_s;

endpackage

// ### testbench/ssfm_flash_model.sv
// Behavioural serial flash on the far side of the link.
// Assumes an idle-high clock, data out on fall, data in on rise.
`timescale 1ns/100ps
module ssfm_flash_model (
  input  wire logic cs_n,
  input  wire logic sclk,
  input  wire logic mosi,
  output logic      miso
);
  logic [7:0] resp_q = 8'h3c;
  logic [7:0] rx_q   = 8'h00;
  int         nbits  = 0;
  initial miso = 1'b0;
  // Drive on fall so the bit is settled at the master's rise
  always @(negedge sclk) begin
    if (!cs_n) begin
      miso <= resp_q[7];
      resp_q <= {resp_q[6:0], resp_q[7]};
    end
  end
  // Capture on rise, first bit ends at the top
  always @(posedge sclk) begin
    if (!cs_n) begin
      rx_q <= {rx_q[6:0], mosi};
      nbits <= nbits + 1;
    end
  end
  // Deselected: flip the line so a stale sample cannot pass
  always @(posedge cs_n) miso <= ~miso;
endmodule

// ### testbench/ssfm_master_assertions.sv
// Port checker for the serial flash master.
// Assumes the constants header is on the include path.
`timescale 1ns/100ps
`include "ssfm_consts.svh"
module ssfm_master_assertions (
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        flash_cs_n,
  input wire logic        flash_sclk,
  input wire logic        flash_mosi,
  input wire logic        flash_miso,
  input wire logic        dma_req
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr;
  logic rd;
  logic wp;
  // Completed accesses
  assign wr = psel && penable && pwrite;
  assign rd = psel && penable && !pwrite;
  assign wp = wr && paddr == `SSFM_OFF_PORT;
  zero_wait_a: assert property (psel && penable |-> pready)
    else $error("pready low in access");
  no_error_a: assert property (pready |-> !pslverr)
    else $error("pslverr raised");
  cs_by_port_a: assert property ($changed(flash_cs_n) |-> $past(wp))
    else $error("select moved without port write");
  cs_readback_a: assert property (rd && paddr == `SSFM_OFF_PORT |-> prdata[0] == flash_cs_n)
    else $error("port read differs from select pin");
  mosi_on_fall_a: assert property ($changed(flash_mosi) |-> $fell(flash_sclk) || $past(wp))
    else $error("data moved off the falling clock");
  req_clear_a: assert property ($fell(dma_req) |-> $past(wr && paddr == `SSFM_OFF_TXIC))
    else $error("request flag dropped by itself");
  idle_high_a: assert property (wp && !pwdata[1] |=> flash_sclk && flash_mosi)
    else $error("pins not high with serial off");
  rx_fields_a: assert property (rd && paddr == `SSFM_OFF_RXB |-> prdata[31:13] == 0 && prdata[11:8] == 0)
    else $error("receive word has stray bits");
  hole_zero_a: assert property (rd && paddr > `SSFM_OFF_PORT |-> prdata == 32'h0)
    else $error("unmapped read not zero");
  cover property ($fell(flash_sclk));
  cover property ($fell(dma_req));
  cover property (rd && paddr == `SSFM_OFF_RXB && prdata[12]);
endmodule
bind ssfm_master ssfm_master_assertions u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk),
  .flash_mosi(flash_mosi), .flash_miso(flash_miso), .dma_req(dma_req));

// ### testbench/test_sync_serial_flash_master.sv
// Self-checking bench for the serial flash master with a flash model.
// Assumes zero-wait APB and byte-wide registers in bits 7:0.
`timescale 1ns/100ps
module test_sync_serial_flash_master;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic        flash_cs_n, flash_sclk, flash_mosi, flash_miso, dma_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [31:0] seed = 32'h7077dd6a;
  logic [7:0]  b;
  logic [11:0] rw[6] = '{12'h008, 12'h018, 12'h01c, 12'h020, 12'h024, 12'h030};
  logic [19:0] cfg[8] = '{20'h00c01, 20'h01090, 20'h00800, 20'h02800, 20'h01405,
                          20'h02c03, 20'h02c02, 20'h02c02};
  int          n_errors = 0, compares = 0, cyc = 0, k, n0;
  ssfm_master dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .flash_cs_n(flash_cs_n), .flash_sclk(flash_sclk),
    .flash_mosi(flash_mosi), .flash_miso(flash_miso), .dma_req(dma_req));
  ssfm_flash_model fm (.cs_n(flash_cs_n), .sclk(flash_sclk), .mosi(flash_mosi),
    .miso(flash_miso));
  initial begin
    pclk = 0;
    forever #20 pclk = ~pclk;
  end
  function automatic logic [31:0] xs();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  task automatic chk(input string nm, input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_errors++;
      $display("Error %s expected %h seen %h", nm, exp, got);
    end
  endtask
  // One APB transfer, then one idle cycle so signals never move twice at once
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int t;
    psel <= 1; pwrite <= w; paddr <= a; pwdata <= d; penable <= 0;
    @(posedge pclk) penable <= 1;
    t = 0;
    do begin @(posedge pclk); t++; end while (pready !== 1'b1 && t < 50);
    chk("pready", pready, 1);
    rv = prdata;
    psel <= 0; penable <= 0;
    @(posedge pclk);
  endtask
  task automatic summarize();
    $display("compares %0d n_errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  // Hang guard, far above the few hundred cycles the run needs
  always @(posedge pclk) begin
    cyc++;
    if (cyc == 20000) begin n_errors++; summarize(); end
  end
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = '0;
    presetn = 0;
    repeat (20) @(posedge pclk);
    chk("reset_pins", {flash_cs_n, flash_sclk, flash_mosi, dma_req}, 4'he);
    presetn <= 1;
    @(posedge pclk);
    for (int a = 'h14; a <= 'h30; a += 4) begin
      apb(0, a, 0);
      chk("reset_val", rv, a == 'h14 ? 2 : a == 'h2c ? 1 : 0);
    end
    $display("reset test done");
    // Random read-back; the last entry is the hole and must stay zero
    for (int i = 0; i < 12; i++) begin
      b = i == 0 ? 8'hff : xs();
      apb(1, rw[i % 6], b);
      apb(0, rw[i % 6], 0);
      chk("rw_val", rv, i % 6 == 5 ? 0 : b);
      apb(1, rw[i % 6], 0);
    end
    $display("register test done");
    // Start order: select high, serial on with clock high, then select low
    foreach (cfg[i]) apb(1, cfg[i][19:8], cfg[i][7:0]);
    chk("clk_idle", flash_sclk, 1);
    for (int i = 0; i < 4; i++) begin
      b = i == 0 ? 8'h00 : i == 1 ? 8'hff : xs();
      n0 = fm.nbits;
      apb(1, 'h00, b);
      k = 0;
      while (dma_req !== 1'b1 && k < 40) begin @(posedge pclk); k++; end
      chk("tx_req", dma_req, 1);
      apb(1, 'h28, 0);
      chk("tx_req_clr", dma_req, 0);
      k = 0;
      do begin apb(0, 'h10, 0); k++; end while (rv[3] !== 1'b1 && k < 30);
      chk("bits", fm.nbits - n0, 8);
      chk("mosi_byte", fm.rx_q, b);
      apb(0, 'h14, 0);
      chk("ctrl1", rv, 32'h0f);
      if (i != 2) begin
        apb(0, 'h04, 0);
        chk("rx_byte", rv, i == 3 ? 32'h103c : 32'h3c);
      end
    end
    $display("transfer test done");
    // End order: select high, then serial off leaves pins high
    apb(1, 'h2c, 3);
    chk("cs_end", flash_cs_n, 1);
    apb(1, 'h2c, 1);
    chk("pins_end", {flash_sclk, flash_mosi}, 2'b11);
    $display("shutdown test done");
    summarize();
  end
endmodule
